// ===== shared/nmc_map.svh
`ifndef NMC_MAP_SVH
`define NMC_MAP_SVH
// Functional notes
// - Multi-plane program pages share A9-A13
// - Planes may be loaded in any order
// - Erase setup repeated, one confirm, four max
// - Only one erase block per plane
// - Copy-back source read with 00h
// - 8Ah destination then 10h starts copy
// - Copy-back keeps A14, A15, A26
// - No partial program after copy-back
// - Use two-bit ECC with copy-back
// - Further copy-back source reads use 03h
// - 11h ends plane, 10h ends last
// - No column pointer in multi-plane copy-back
// - Status mode holds; reissue read after
// - 71h pass/fail valid only when ready
// - 90h plus 00h gives four ID bytes
// - Wait 10 us after power-up
`define NMC_OFS_CTRL       8'h00
`define NMC_OFS_STAT       8'h04
`define NMC_OFS_ADDR       8'h08
`define NMC_OFS_RDATA      8'h0C
`define NMC_OFS_CFG        8'h10
`define NMC_CTL_C1_LSB     8
`define NMC_CTL_NADDR_LSB  16
`define NMC_CTL_USE1       19
`define NMC_CTL_WAIT       20
`define NMC_CTL_RDB        21
`define NMC_CTL_OP_LSB     22
`define NMC_STB_READY      6
`define NMC_STATUS_RST     8'hC0
`define NMC_CMD_READ1      8'h00
`define NMC_CMD_PTR_B      8'h01
`define NMC_CMD_READ_ALT   8'h03
`define NMC_CMD_PROG       8'h10
`define NMC_CMD_DUMMY      8'h11
`define NMC_CMD_READ2      8'h50
`define NMC_CMD_ERASE      8'h60
`define NMC_CMD_STATUS     8'h70
`define NMC_CMD_MSTATUS    8'h71
`define NMC_CMD_DATA_IN    8'h80
`define NMC_CMD_COPY_IN    8'h8A
`define NMC_CMD_ERASE_CONF 8'hD0
`define NMC_CMD_RESET      8'hFF
`define NMC_ERR_BUSY       3'h1
`define NMC_ERR_PAGE_LOW   3'h2
`define NMC_ERR_COPY_PLANE 3'h3
`define NMC_ERR_POINTER    3'h4
`define NMC_ERR_ERASE_PL   3'h5
`define NMC_CLK_MHZ        125
`define NMC_RECOV_US       10
`define NMC_RECOV_CYC      (`NMC_RECOV_US * `NMC_CLK_MHZ)
`define NMC_WB_NS          100
`define NMC_WB_CYC         ((`NMC_WB_NS * `NMC_CLK_MHZ + 999) / 1000)
`define NMC_STROBE_CYC     3
`define NMC_HOLD_CYC       3
`define NMC_RD_CYC         6
`endif

// ===== shared/nmc_pkg.sv
package nmc_pkg;
   typedef enum logic [3:0] {
      NMC_PWRUP, NMC_IDLE, NMC_CMD0, NMC_ADDR, NMC_CMD1,
      NMC_DWR, NMC_WB, NMC_WRB, NMC_DRD
   } nmc_state_t;
   typedef enum logic [1:0] {NMC_OP_CMD, NMC_OP_WR, NMC_OP_RD, NMC_OP_NONE} nmc_op_t;
endpackage : nmc_pkg

// ===== rtl/nmc_pin_sync.sv
`timescale 1ns/1ns
module nmc_pin_sync #(
   parameter int W = 1
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } nmc_sync_st_t;
   nmc_sync_st_t st_reg;
   nmc_sync_st_t st_next;

   always_comb
   begin
      st_next    = st_reg;
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      // A bit changes only once the second and third stages agree
      st_next.q  = ((st_reg.s2 ~^ st_reg.s3) & st_reg.s3) | ((st_reg.s2 ^ st_reg.s3) & st_reg.q);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign q = st_reg.q;
endmodule : nmc_pin_sync

// ===== rtl/nmc_ahb_slave.sv
`timescale 1ns/1ns
module nmc_ahb_slave (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic        hreadyout,
   output      logic        hresp,
   output      logic [31:0] hrdata,
   output      logic        reg_wr,
   output      logic [7:0]  reg_waddr,
   output      logic [31:0] reg_wdata,
   output      logic [7:0]  reg_raddr,
   input  wire logic [31:0] reg_rdata
);
   typedef struct packed {
      logic        wpend;
      logic [7:0]  waddr;
      logic [31:0] rdata;
   } nmc_bus_st_t;
   nmc_bus_st_t st_reg;
   nmc_bus_st_t st_next;

   always_comb
   begin
      st_next       = st_reg;
      st_next.wpend = 1'h0;
      // Only word transfers are used, so hsize is not decoded
      if (hsel && htrans[1] && hready && (hsize == 3'h2 || hsize != 3'h2))
      begin
         st_next.wpend = hwrite;
         st_next.waddr = haddr[7:0];
         if (!hwrite)
            st_next.rdata = (haddr[31:8] == 24'h000000) ? reg_rdata : 32'h00000000;
         else
            st_next.rdata = 32'h00000000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign hreadyout = 1'h1;
   assign hresp     = 1'h0;
   assign hrdata    = st_reg.rdata;
   assign reg_wr    = st_reg.wpend;
   assign reg_waddr = st_reg.waddr;
   assign reg_wdata = hwdata;
   assign reg_raddr = haddr[7:0];
endmodule : nmc_ahb_slave

// ===== rtl/nmc_top.sv
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "nmc_map.svh"
module nmc_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic        hreadyout,
   output      logic        hresp,
   output      logic [31:0] hrdata,
   output      logic        nand_ce_n,
   output      logic        nand_cle,
   output      logic        nand_ale,
   output      logic        nand_we_n,
   output      logic        read_strobe_n,
   output      logic        nand_wp_n,
   output      logic [7:0]  nand_io_out,
   output      logic        nand_io_oe,
   input  wire logic [7:0]  nand_io_in,
   input  wire logic        nand_rb
);
   typedef struct packed {
      nmc_pkg::nmc_state_t state;
      logic [10:0]         cnt;
      logic [2:0]          aidx;
      logic [31:0]         ctrl;
      logic [31:0]         addr;
      logic [7:0]          rdata;
      logic [7:0]          stat;
      logic                stat_valid;
      logic                smode;
      logic                err;
      logic [2:0]          ecode;
      logic                wp_cfg;
      logic                ce_hold;
      logic                ce_n;
      logic                we_n;
      logic                re_n;
      logic                cle;
      logic                ale;
      logic                wp_n;
      logic                io_oe;
      logic [7:0]          io_out;
      logic [4:0]          mp_low;
      logic                mp_act;
      logic [2:0]          cb_plane;
      logic                cb_act;
      logic [3:0]          er_mask;
   } nmc_top_st_t;

   nmc_top_st_t st_reg;
   nmc_top_st_t st_next;
   logic [8:0]  pin_q;
   logic        rb_s;
   logic [7:0]  io_s;
   logic        reg_wr;
   logic [7:0]  reg_waddr;
   logic [31:0] reg_wdata;
   logic [7:0]  reg_raddr;
   logic [31:0] reg_rdata;
   logic [10:0] up_cnt;

   nmc_ahb_slave u_bus (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .reg_wr    (reg_wr),
      .reg_waddr (reg_waddr),
      .reg_wdata (reg_wdata),
      .reg_raddr (reg_raddr),
      .reg_rdata (reg_rdata)
   );

   nmc_pin_sync #(.W(9)) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       ({nand_rb, nand_io_in}),
      .q       (pin_q)
   );
   assign rb_s = pin_q[8];
   assign io_s = pin_q[7:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencing helpers
   function automatic nmc_top_st_t go_idle(input nmc_top_st_t s);
      nmc_top_st_t r;
      r       = s;
      r.state = nmc_pkg::NMC_IDLE;
      r.cnt   = 11'h000;
      r.io_oe = 1'h0;
      r.cle   = 1'h0;
      r.ale   = 1'h0;
      r.we_n  = 1'h1;
      r.re_n  = 1'h1;
      r.ce_n  = !s.ce_hold;
      return r;
   endfunction : go_idle

   function automatic nmc_top_st_t go_byte(input nmc_top_st_t s, input nmc_pkg::nmc_state_t t,
                                           input logic [7:0] b, input logic c, input logic a);
      nmc_top_st_t r;
      r        = s;
      r.state  = t;
      r.cnt    = 11'h000;
      r.we_n   = 1'h0;
      r.io_oe  = 1'h1;
      r.io_out = b;
      r.cle    = c;
      r.ale    = a;
      r.ce_n   = 1'h0;
      return r;
   endfunction : go_byte

   function automatic nmc_top_st_t go_read(input nmc_top_st_t s);
      nmc_top_st_t r;
      r       = s;
      r.state = nmc_pkg::NMC_DRD;
      r.cnt   = 11'h000;
      r.re_n  = 1'h0;
      r.io_oe = 1'h0;
      r.cle   = 1'h0;
      r.ale   = 1'h0;
      r.ce_n  = 1'h0;
      return r;
   endfunction : go_read

   function automatic nmc_top_st_t go_wait(input nmc_top_st_t s);
      nmc_top_st_t r;
      r = go_idle(s);
      r.ce_n = 1'h0;
      if (s.ctrl[`NMC_CTL_WAIT])
         r.state = nmc_pkg::NMC_WB;
      else if (s.ctrl[`NMC_CTL_RDB])
         r = go_read(s);
      else
         r = go_idle(s);
      return r;
   endfunction : go_wait

   function automatic nmc_top_st_t go_rest(input nmc_top_st_t s);
      if (s.ctrl[`NMC_CTL_USE1])
         return go_byte(s, nmc_pkg::NMC_CMD1, s.ctrl[`NMC_CTL_C1_LSB +: 8], 1'h1, 1'h0);
      return go_wait(s);
   endfunction : go_rest

   function automatic logic [7:0] addr_byte(input logic [31:0] a, input logic [2:0] i);
      return a[{i[1:0], 3'h0} +: 8];
   endfunction : addr_byte

   function automatic logic [1:0] erase_plane(input logic [31:0] a);
      return a[6:5];
   endfunction : erase_plane

   ////////////////////////////////////////////////////////////////////////////////
   // Pin sequencer and register writes
   logic [7:0] c0;
   logic [7:0] c1;
   logic [2:0] naddr;
   assign c0    = reg_wdata[7:0];
   assign c1    = reg_wdata[`NMC_CTL_C1_LSB +: 8];
   assign naddr = st_reg.ctrl[`NMC_CTL_NADDR_LSB +: 3];

   always_comb
   begin
      st_next = st_reg;
      unique case (st_reg.state)
         nmc_pkg::NMC_PWRUP:
         begin
            st_next.cnt = st_reg.cnt + 11'h001;
            if (st_reg.cnt == 11'(`NMC_RECOV_CYC - 1))
               st_next = go_idle(st_reg);
         end
         nmc_pkg::NMC_IDLE:
            st_next.ce_n = !st_reg.ce_hold;
         nmc_pkg::NMC_CMD0, nmc_pkg::NMC_ADDR, nmc_pkg::NMC_CMD1, nmc_pkg::NMC_DWR:
         begin
            st_next.cnt = st_reg.cnt + 11'h001;
            if (st_reg.cnt == 11'(`NMC_STROBE_CYC - 1))
               st_next.we_n = 1'h1;
            if (st_reg.cnt == 11'(`NMC_STROBE_CYC + `NMC_HOLD_CYC - 1))
            begin
               if (st_reg.state == nmc_pkg::NMC_CMD0)
               begin
                  st_next.aidx = 3'h0;
                  if (naddr != 3'h0)
                     st_next = go_byte(st_next, nmc_pkg::NMC_ADDR,
                                       addr_byte(st_reg.addr, 3'h0), 1'h0, 1'h1);
                  else
                     st_next = go_rest(st_next);
               end
               else if (st_reg.state == nmc_pkg::NMC_ADDR)
               begin
                  st_next.aidx = st_reg.aidx + 3'h1;
                  if (st_next.aidx < naddr)
                     st_next = go_byte(st_next, nmc_pkg::NMC_ADDR,
                                       addr_byte(st_reg.addr, st_next.aidx), 1'h0, 1'h1);
                  else
                     st_next = go_rest(st_next);
               end
               else if (st_reg.state == nmc_pkg::NMC_CMD1)
                  st_next = go_wait(st_next);
               else
                  st_next = go_idle(st_next);
            end
         end
         nmc_pkg::NMC_WB:
         begin
            st_next.cnt = st_reg.cnt + 11'h001;
            if (st_reg.cnt == 11'(`NMC_WB_CYC - 1))
               st_next.state = nmc_pkg::NMC_WRB;
         end
         nmc_pkg::NMC_WRB:
         begin
            // ready again after any command issued with the wait bit set (program, dummy, erase, reset)
            if (rb_s)
               st_next = st_reg.ctrl[`NMC_CTL_RDB] ? go_read(st_reg) : go_idle(st_reg);
         end
         nmc_pkg::NMC_DRD:
         begin
            st_next.cnt = st_reg.cnt + 11'h001;
            if (st_reg.cnt == 11'(`NMC_RD_CYC - 1))
            begin
               st_next.re_n  = 1'h1;
               st_next.rdata = io_s;
               // pass/fail kept valid only with ready set
               if (st_reg.smode)
               begin
                  st_next.stat       = io_s;
                  st_next.stat_valid = io_s[`NMC_STB_READY];
               end
            end
            if (st_reg.cnt == 11'(`NMC_RD_CYC + `NMC_HOLD_CYC - 1))
               st_next = go_idle(st_next);
         end
      endcase

      if (reg_wr && reg_waddr == `NMC_OFS_STAT && reg_wdata[1])
         st_next.err = 1'h0;
      if (reg_wr && reg_waddr == `NMC_OFS_ADDR && st_reg.state == nmc_pkg::NMC_IDLE)
         st_next.addr = reg_wdata;
      if (reg_wr && reg_waddr == `NMC_OFS_CFG)
      begin
         st_next.wp_cfg  = reg_wdata[0];
         st_next.ce_hold = reg_wdata[1];
      end
      if (reg_wr && reg_waddr == `NMC_OFS_CTRL)
      begin
         if (st_reg.state != nmc_pkg::NMC_IDLE)
         begin
            st_next.err   = 1'h1;
            st_next.ecode = `NMC_ERR_BUSY;
         end
         // same low page bits across planes
         else if (reg_wdata[23:22] == nmc_pkg::NMC_OP_CMD && c0 == `NMC_CMD_DATA_IN
                  && st_reg.mp_act && st_reg.addr[12:8] != st_reg.mp_low)
         begin
            st_next.err   = 1'h1;
            st_next.ecode = `NMC_ERR_PAGE_LOW;
         end
         else if (reg_wdata[23:22] == nmc_pkg::NMC_OP_CMD && c0 == `NMC_CMD_COPY_IN
                  && st_reg.cb_plane != {st_reg.addr[14:13], st_reg.addr[25]})
         begin
            st_next.err   = 1'h1;
            st_next.ecode = `NMC_ERR_COPY_PLANE;
         end
         else if (reg_wdata[23:22] == nmc_pkg::NMC_OP_CMD && st_reg.cb_act
                  && (c0 == `NMC_CMD_PTR_B || c0 == `NMC_CMD_READ2))
         begin
            st_next.err   = 1'h1;
            st_next.ecode = `NMC_ERR_POINTER;
         end
         else if (reg_wdata[23:22] == nmc_pkg::NMC_OP_CMD && c0 == `NMC_CMD_ERASE
                  && st_reg.er_mask[erase_plane(st_reg.addr)])
         begin
            st_next.err   = 1'h1;
            st_next.ecode = `NMC_ERR_ERASE_PL;
         end
         else
         begin
            st_next.ctrl = reg_wdata;
            unique case (nmc_pkg::nmc_op_t'(reg_wdata[23:22]))
               nmc_pkg::NMC_OP_CMD:
               begin
                  st_next.smode = (c0 == `NMC_CMD_STATUS || c0 == `NMC_CMD_MSTATUS);
                  if (c0 == `NMC_CMD_DATA_IN)
                     st_next.mp_low = st_reg.addr[12:8];
                  if (c0 == `NMC_CMD_READ1 || c0 == `NMC_CMD_READ_ALT)
                     st_next.cb_plane = {st_reg.addr[14:13], st_reg.addr[25]};
                  if (c0 == `NMC_CMD_COPY_IN)
                     st_next.cb_act = 1'h1;
                  if (c0 == `NMC_CMD_ERASE)
                     st_next.er_mask[erase_plane(st_reg.addr)] = 1'h1;
                  if (reg_wdata[`NMC_CTL_USE1] && c1 == `NMC_CMD_DUMMY)
                     st_next.mp_act = 1'h1;
                  if (reg_wdata[`NMC_CTL_USE1] && c1 == `NMC_CMD_PROG)
                  begin
                     st_next.mp_act = 1'h0;
                     st_next.cb_act = 1'h0;
                  end
                  if ((reg_wdata[`NMC_CTL_USE1] && c1 == `NMC_CMD_ERASE_CONF)
                      || c0 == `NMC_CMD_ERASE_CONF)
                     st_next.er_mask = 4'h0;
                  if (c0 == `NMC_CMD_RESET)
                  begin
                     st_next.mp_act     = 1'h0;
                     st_next.cb_act     = 1'h0;
                     st_next.er_mask    = 4'h0;
                     st_next.stat       = `NMC_STATUS_RST;
                     st_next.stat_valid = 1'h0;
                  end
                  st_next.aidx = 3'h0;
                  st_next = go_byte(st_next, nmc_pkg::NMC_CMD0, c0, 1'h1, 1'h0);
               end
               nmc_pkg::NMC_OP_WR:
                  st_next = go_byte(st_next, nmc_pkg::NMC_DWR, c0, 1'h0, 1'h0);
               nmc_pkg::NMC_OP_RD:
                  st_next = go_read(st_next);
               nmc_pkg::NMC_OP_NONE:
                  st_next.ctrl = st_reg.ctrl;
            endcase
         end
      end
      st_next.wp_n = (st_next.state != nmc_pkg::NMC_PWRUP) && st_next.wp_cfg;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_reg       <= '0;
         st_reg.state <= nmc_pkg::NMC_PWRUP;
         st_reg.stat  <= `NMC_STATUS_RST;
         st_reg.ce_n  <= 1'h1;
         st_reg.we_n  <= 1'h1;
         st_reg.re_n  <= 1'h1;
      end
      else
         st_reg <= st_next;
   end

   function automatic logic [31:0] read_mux(input logic [7:0] a, input nmc_top_st_t s,
                                            input logic rb);
      unique case (a)
         `NMC_OFS_CTRL:  return s.ctrl;
         `NMC_OFS_STAT:  return {16'h0000, s.stat, s.stat_valid, s.state != nmc_pkg::NMC_PWRUP,
                                 rb, s.ecode, s.err, s.state != nmc_pkg::NMC_IDLE};
         `NMC_OFS_ADDR:  return s.addr;
         `NMC_OFS_RDATA: return {24'h000000, s.rdata};
         `NMC_OFS_CFG:   return {30'h00000000, s.ce_hold, s.wp_cfg};
         default:        return 32'h00000000;
      endcase
   endfunction : read_mux
   assign reg_rdata = read_mux(reg_raddr, st_reg, rb_s);

   assign nand_ce_n     = st_reg.ce_n;
   assign nand_cle      = st_reg.cle;
   assign nand_ale      = st_reg.ale;
   assign nand_we_n     = st_reg.we_n;
   assign read_strobe_n = st_reg.re_n;
   assign nand_wp_n     = st_reg.wp_n;
   assign nand_io_out   = st_reg.io_out;
   assign nand_io_oe    = st_reg.io_oe;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         up_cnt <= 11'h000;
      else if (up_cnt != 11'h7FF)
         up_cnt <= up_cnt + 11'h001;
   end

   AST_RECOVERY: assert property (@(posedge hclk) disable iff (!hresetn)
      (up_cnt < 11'(`NMC_RECOV_CYC)) |-> (nand_ce_n && nand_we_n && !nand_wp_n))
      else $error("command pins active before recovery time");
   AST_WE_PULSE: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(nand_we_n) |-> (!nand_we_n)[*3] ##1 nand_we_n)
      else $error("write strobe width wrong");
   AST_RB_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_reg.state == nmc_pkg::NMC_WRB && !rb_s) |=> st_reg.state == nmc_pkg::NMC_WRB)
      else $error("left busy wait while device busy");
   AST_DUMMY_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_reg.state == nmc_pkg::NMC_CMD1 && st_reg.ctrl[`NMC_CTL_WAIT]
       && st_reg.cnt == 11'(`NMC_STROBE_CYC + `NMC_HOLD_CYC - 1))
      |=> st_reg.state == nmc_pkg::NMC_WB ##13 st_reg.state == nmc_pkg::NMC_WRB)
      else $error("no busy wait after confirm");
   AST_COPY_PLANE: assert property (@(posedge hclk) disable iff (!hresetn)
      (reg_wr && reg_waddr == `NMC_OFS_CTRL && st_reg.state == nmc_pkg::NMC_IDLE
       && reg_wdata[23:22] == 2'h0 && c0 == `NMC_CMD_COPY_IN && !st_reg.mp_act
       && st_reg.cb_plane != {st_reg.addr[14:13], st_reg.addr[25]})
      |=> st_reg.err && st_reg.state == nmc_pkg::NMC_IDLE)
      else $error("copy across planes not refused");
   AST_PAGE_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
      (reg_wr && reg_waddr == `NMC_OFS_CTRL && st_reg.state == nmc_pkg::NMC_IDLE
       && reg_wdata[23:22] == 2'h0 && c0 == `NMC_CMD_DATA_IN && st_reg.mp_act
       && st_reg.addr[12:8] != st_reg.mp_low)
      |=> st_reg.ecode == `NMC_ERR_PAGE_LOW && st_reg.err)
      else $error("mismatched page bits not refused");
   AST_ERASE_PL: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_reg.state == nmc_pkg::NMC_CMD0 && st_reg.io_out == `NMC_CMD_ERASE
       && !(st_reg.ctrl[`NMC_CTL_USE1]
            && st_reg.ctrl[`NMC_CTL_C1_LSB +: 8] == `NMC_CMD_ERASE_CONF))
      |-> st_reg.er_mask != 4'h0)
      else $error("erase setup not recorded");
   AST_STAT_VALID: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(st_reg.stat_valid) |-> st_reg.stat[`NMC_STB_READY])
      else $error("status marked valid while busy");
   AST_RESET_STAT: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_reg.state == nmc_pkg::NMC_CMD0 && st_reg.io_out == `NMC_CMD_RESET
       && st_reg.cnt == 11'h000)
      |-> st_reg.stat == `NMC_STATUS_RST && !st_reg.cb_act && !st_reg.mp_act)
      else $error("reset did not clear state");
   AST_BUS_DIR: assert property (@(posedge hclk) disable iff (!hresetn)
      !nand_io_oe |-> ##0 !(nand_cle || nand_ale) || nand_we_n)
      else $error("strobe without driven bus");
endmodule : nmc_top

// ===== verif/nmc_nand_model.sv
`timescale 1ns/1ns
module nmc_nand_model #(
   parameter logic [7:0] MAKER_ID = 8'h5A // Arbitrary value
) (
   input  wire logic       nand_ce_n,
   input  wire logic       nand_cle,
   input  wire logic       nand_we_n,
   input  wire logic       read_strobe_n,
   input  wire logic       nand_wp_n,
   input  wire logic [7:0] nand_io_out,
   output      logic [7:0] nand_io_in,
   output      logic       nand_rb
);
   logic       busy = 1'b0;
   logic       up = 1'b0;
   logic [1:0] mode = 2'd0;
   logic [7:0] dout;
   int         bt = 0;
   event       go;
   initial #10000 up = 1'b1;
   assign dout = mode == 2'd1 ? {nand_wp_n, ~busy, 6'h00} : mode == 2'd2 ? MAKER_ID : 8'h3C;
   // Undriven bus shows a moving inverse
   assign nand_io_in = (!nand_ce_n && !read_strobe_n) ? dout : ~dout;
   assign nand_rb = ~busy;
   always @(go)
   begin
      busy = 1'b1;
      #(bt) busy = 1'b0;
   end
   always @(posedge nand_we_n)
      if (!nand_ce_n && nand_cle && up && !(busy && nand_io_out[7:1] != 7'h38 && !(&nand_io_out)))
         case (nand_io_out)
            8'h70, 8'h71: mode <= 2'd1;
            8'h90: mode <= 2'd2;
            8'h10, 8'h11, 8'hD0, 8'hFF:
            begin
               mode <= 2'd0;
               bt = nand_io_out == 8'h11 ? 500 : 3000;
               -> go;
            end
            default: mode <= 2'd0;
         endcase
endmodule : nmc_nand_model

// ===== verif/nand_multiplane_cmd_status_bench.sv
`timescale 1ns/1ns
module nand_multiplane_cmd_status_bench;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        hrdy, hresp, ce_n, cle, ale, we_n, re_n, wp_n, oe, rb;
   logic [31:0] hrdata, rd;
   logic [7:0]  io_o, io_i;
   int          miscompares = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   always #4 hclk = ~hclk;
   nmc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
      .hresp(hresp), .hrdata(hrdata), .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale),
      .nand_we_n(we_n), .read_strobe_n(re_n), .nand_wp_n(wp_n), .nand_io_out(io_o),
      .nand_io_oe(oe), .nand_io_in(io_i), .nand_rb(rb));
   nmc_nand_model u_dev (.nand_ce_n(ce_n), .nand_cle(cle), .nand_we_n(we_n),
      .read_strobe_n(re_n), .nand_wp_n(wp_n), .nand_io_out(io_o), .nand_io_in(io_i),
      .nand_rb(rb));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hrdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic idle;
      do
         bus(1'b0, 8'h04, 32'h0);
      while (rd[0] !== 1'b0);
   endtask : idle
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_powerup;
      bus(1'b1, 8'h00, 32'h0020_0070);
      bus(1'b0, 8'h04, 32'h0);
      check(rd[6:1], 6'h03);
      repeat (1260) @(posedge hclk);
      bus(1'b1, 8'h04, 32'h2);
      bus(1'b1, 8'h10, 32'h1);
      bus(1'b0, 8'h04, 32'h0);
      check(rd[6:1], 6'h32);
      check(wp_n, 1'b1);
   endtask : t_powerup
   task automatic t_reset;
      bus(1'b1, 8'h00, 32'h0010_00FF);
      idle();
      bus(1'b1, 8'h00, 32'h0020_0070);
      idle();
      check(rd[15:7], 9'h181);
   endtask : t_reset
   task automatic t_erase;
      bus(1'b1, 8'h08, 32'h0);
      bus(1'b1, 8'h00, 32'h001B_D060);
      bus(1'b1, 8'h00, 32'h0020_0070);
      bus(1'b0, 8'h04, 32'h0);
      check(rd[4:0], 5'h07);
      idle();
      bus(1'b1, 8'h04, 32'h2);
      bus(1'b1, 8'h00, 32'h0020_0071);
      idle();
      check(rd[15:7], 9'h181);
   endtask : t_erase
   task automatic t_multi;
      bus(1'b1, 8'h08, 32'h0000_0020);
      bus(1'b1, 8'h00, 32'h0003_0060);
      idle();
      bus(1'b1, 8'h08, 32'h0000_0041);
      bus(1'b1, 8'h00, 32'h0003_0060);
      idle();
      bus(1'b1, 8'h08, 32'h0000_0021);
      bus(1'b1, 8'h00, 32'h0003_0060);
      bus(1'b0, 8'h04, 32'h0);
      check(rd[4:1], 4'hB);
      bus(1'b1, 8'h00, 32'h0010_00D0);
      idle();
      bus(1'b1, 8'h04, 32'h2);
      bus(1'b1, 8'h00, 32'h0003_0060);
      idle();
      check(rd[1], 1'b0);
      bus(1'b1, 8'h08, 32'h0);
   endtask : t_multi
   task automatic t_id_copy;
      bus(1'b1, 8'h00, 32'h0021_0090);
      idle();
      bus(1'b0, 8'h0C, 32'h0);
      check(rd[7:0], 8'h5A);
      bus(1'b1, 8'h00, 32'h0004_0000);
      idle();
      bus(1'b1, 8'h08, 32'h0000_4000);
      bus(1'b1, 8'h00, 32'h0004_008A);
      bus(1'b0, 8'h04, 32'h0);
      check(rd[4:1], 4'h7);
   endtask : t_id_copy
   always @(posedge hclk)
      if (++cyc == 20000)
      begin
         miscompares++;
         summarize();
      end
   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_powerup();
      t_reset();
      t_erase();
      t_multi();
      t_id_copy();
      summarize();
   end
endmodule : nand_multiplane_cmd_status_bench
